// file: bench/coupler_model.sv
// Bus coupler stand-in: runs one register access per request via the control byte.
// Assumes the bench pulses go_i for one cycle, holds ch_i and waits for done_o.
module coupler_model
    import terminal_channel_pkg::*;
(
    input  wire logic                      ref_clk_i,
    input  wire logic                      go_i,
    input  wire logic                      ch_i,
    input  wire logic [7:0]                cmd_i,
    input  wire logic [15:0]               wdata_i,
    input  wire logic [CHANNELS-1:0][7:0]  status_byte_i,
    output logic      [CHANNELS-1:0][7:0]  ctrl_byte_o = '0,
    output logic      [CHANNELS-1:0][15:0] out_data_o = '0,
    output logic                           done_o = 1'b0
);
    ////////////////////////////////////////////////////////////////
    logic busy = 1'b0;
    always @(posedge ref_clk_i)
    begin
        done_o <= 1'b0;
        if (go_i)
        begin
            ctrl_byte_o[ch_i] <= cmd_i;
            out_data_o[ch_i]  <= wdata_i;
            busy              <= 1'b1;
        end
        else if (busy && status_byte_i[ch_i] == ctrl_byte_o[ch_i])
        begin
            // drop bit 7 after the echo so that a repeat is seen as a new access
            ctrl_byte_o[ch_i] <= 8'h00;
            busy              <= 1'b0;
            done_o            <= 1'b1;
        end
    end
endmodule // coupler_model

// file: bench/terminal_channel_register_set_asserts.sv
// Port-level checks for the terminal channel register set.
// Assumes link_control only changes while no control byte has bit 7 set.
module terminal_channel_register_set_asserts
    import terminal_channel_pkg::*;
(
    input wire logic                      ref_clk_i,
    input wire logic                      rst_n_i,
    input wire logic [BUS_ADDR_W-1:0]     avs_address_i,
    input wire logic                      avs_read_i,
    input wire logic                      avs_write_i,
    input wire logic [31:0]               avs_writedata_i,
    input wire logic [31:0]               avs_readdata_o,
    input wire logic                      avs_waitrequest_o,
    input wire logic [CHANNELS-1:0][7:0]  ctrl_byte_i,
    input wire logic [CHANNELS-1:0][15:0] out_data_i,
    input wire logic [CHANNELS-1:0][7:0]  status_byte_o,
    input wire logic [CHANNELS-1:0][15:0] in_data_o
);
    ////////////////////////////////////////////////////////////////
    // shadow lags the device by one edge, harmless while enables move only when idle
    logic [1:0] link_en;
    logic [1:0] pend;
    logic       rd_ans;
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            link_en <= 2'h0;
        else if (avs_write_i && !avs_waitrequest_o && avs_address_i == LINK_CONTROL_ADDR)
            link_en <= avs_writedata_i[1:0];
    end
    assign pend[0] = link_en[0] && ctrl_byte_i[0][7] && ctrl_byte_i[0] != status_byte_o[0];
    assign pend[1] = link_en[1] && ctrl_byte_i[1][7] && ctrl_byte_i[1] != status_byte_o[1];
    assign rd_ans  = avs_read_i && !avs_waitrequest_o && !avs_address_i[LOCAL_SPACE_BIT];
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held too long");
    bus_stall_a: assert property (!avs_waitrequest_o |-> $past(pend) == 2'h0)
        else $error("bus answered during coupler access");
    idle_status_a: assert property (!ctrl_byte_i[0][7] |=> status_byte_o[0] == 8'h00)
        else $error("status not cleared");
    ack_ch0_a: assert property (pend[0] |=> status_byte_o[0] == $past(ctrl_byte_i[0]))
        else $error("channel 0 no echo");
    ack_ch1_a: assert property (pend[1] |=> status_byte_o[1] == $past(ctrl_byte_i[1]))
        else $error("channel 1 no echo");
    type_link_a: assert property (pend[1] && ctrl_byte_i[1] == 8'h88
        |=> in_data_o[1] == TYPE_CODE_VALUE) else $error("coupler type read wrong");
    type_bus_a: assert property (rd_ans && avs_address_i[7:0] == 8'h20
        |-> avs_readdata_o == {16'h0000, TYPE_CODE_VALUE}) else $error("type word wrong");
    ext_zero_a: assert property (rd_ans && avs_address_i[7:2] >= EXTENDED_FIRST
        |-> avs_readdata_o == 32'h0000_0000) else $error("extended word not zero");
endmodule // terminal_channel_register_set_asserts
bind terminal_channel_register_set terminal_channel_register_set_asserts u_asserts (.*);

// file: bench/terminal_channel_register_set_tb_top.sv
// Self-checking bench, one task per scenario.
// Assumes the coupler stand-in drives the process image and the checker is bound in.
module terminal_channel_register_set_tb_top
    import terminal_channel_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    ////////////////////////////////////////////////////////////////
    logic                      ref_clk_i = 1'b0;
    logic                      rst_n_i = 1'b0;
    logic [BUS_ADDR_W-1:0]     avs_address_i = '0;
    logic                      avs_read_i = 1'b0;
    logic                      avs_write_i = 1'b0;
    logic [31:0]               avs_writedata_i = '0;
    logic [31:0]               avs_readdata_o, rd;
    logic                      avs_waitrequest_o, done, go = 1'b0, ch = 1'b0;
    logic [CHANNELS-1:0][7:0]  ctrl_byte_i, status_byte_o;
    logic [CHANNELS-1:0][15:0] out_data_i, in_data_o;
    logic [7:0]                cmd = '0, cst;
    logic [15:0]               wdat = '0, cin;
    int                        fail_count = 0, n_compared = 0;
    initial
    begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    terminal_channel_register_set DUT (.*);
    coupler_model u_coupler (.ref_clk_i(ref_clk_i), .go_i(go), .ch_i(ch), .cmd_i(cmd), .wdata_i(wdat),
        .status_byte_i(status_byte_o), .ctrl_byte_o(ctrl_byte_i), .out_data_o(out_data_i), .done_o(done));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // bus answer or coupler completion; a spent bound ends the run
    task automatic await(input logic bus_side);
        int n;
        n = 0;
        do
        begin
            @(negedge ref_clk_i);
            n++;
        end
        while ((bus_side ? avs_waitrequest_o !== 1'b0 : done !== 1'b1) && n < 64);
        if (n >= 64)
        begin
            fail_count++;
            stop_test();
        end
    endtask
    function automatic logic [9:0] ra(input logic c, input logic [5:0] i);
        return {1'b0, c, i, 2'h0};
    endfunction
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        await(1'b1);
        @(posedge ref_clk_i);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic cpl(input logic c, input logic [7:0] k, input logic [15:0] d);
        @(posedge ref_clk_i);
        ch   <= c;
        cmd  <= k;
        wdat <= d;
        go   <= 1'b1;
        @(posedge ref_clk_i);
        go <= 1'b0;
        await(1'b0);
        cst = status_byte_o[c];
        cin = in_data_o[c];
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_process();
        check(avs_readdata_o, 32'h0);
        bus(1'b1, ra(1'b0, 6'h00), 32'h0000_BEEF);
        @(negedge ref_clk_i);
        check(32'(in_data_o[0]), 32'h0000_BEEF);
        check(32'(status_byte_o[0]), 32'h0);
    endtask
    task automatic t_types();
        logic [15:0] tw [6] = '{TYPE_CODE_VALUE, FIRMWARE_VALUE, SHIFT_LENGTH_VALUE,
            CHANNEL_COUNT_VALUE, MIN_TRANSFER_VALUE, DATA_TYPE_VALUE};
        for (int c = 0; c < 2; c++)
            for (int i = 0; i < 6; i++)
            begin
                bus(1'b1, ra(c[0], 6'(8 + i)), 32'h0000_FFFF);
                bus(1'b0, ra(c[0], 6'(8 + i)), 32'h0);
                check(rd, 32'(tw[i]));
            end
    endtask
    task automatic t_areas();
        logic [5:0]  idx [4] = '{6'h05, 6'h14, 6'h28, 6'h32};
        logic [31:0] v;
        for (int p = 0; p < 2; p++)
            for (int c = 0; c < 2; c++)
                for (int i = 0; i < 4; i++)
                begin
                    v = 32'((c + 1) * 32'h1000 + idx[i]);
                    if (p == 0)
                        bus(1'b1, ra(c[0], idx[i]), v);
                    else
                    begin
                        bus(1'b0, ra(c[0], idx[i]), 32'h0);
                        check(rd, (idx[i] >= EXTENDED_FIRST) ? 32'h0 : v);
                    end
                end
        bus(1'b0, 10'h002, 32'h0);
        check(rd, 32'h0);
    endtask
    task automatic t_coupler();
        bus(1'b1, LINK_CONTROL_ADDR, 32'h0000_0003);
        bus(1'b0, LINK_CONTROL_ADDR, 32'h0);
        check(rd, 32'h0000_0003);
        cpl(1'b1, 8'h88, 16'h0000);
        check(32'(cst), 32'h88);
        check(32'(cin), 32'(TYPE_CODE_VALUE));
        cpl(1'b0, 8'hD4, 16'h1234);
        bus(1'b0, ra(1'b0, 6'h14), 32'h0);
        check(rd, 32'h0000_1234);
        cpl(1'b0, 8'hC8, 16'h5555);
        bus(1'b0, ra(1'b0, 6'h08), 32'h0);
        check(rd, 32'(TYPE_CODE_VALUE));
        bus(1'b0, ra(1'b0, DIAGNOSTIC_INFO), 32'h0);
        check(rd, 32'h0000_0001);
    endtask
    task automatic t_command();
        bus(1'b1, ra(1'b0, FUNCTION_COMMAND), 32'h0000_AB00);
        cpl(1'b0, 8'hC7, 16'h5503);
        bus(1'b0, ra(1'b0, FUNCTION_COMMAND), 32'h0);
        check(rd, 32'h0000_5503);
        cpl(1'b0, 8'h87, 16'h0000);
        check(32'(cin), 32'h0000_AB03);
    endtask
    // bus request raised while a coupler access is pending must wait for it
    task automatic t_stall();
        fork
            cpl(1'b0, 8'h88, 16'h0000);
            begin
                @(posedge ref_clk_i);
                bus(1'b0, ra(1'b0, 6'h14), 32'h0);
            end
        join
        check(32'(cst), 32'h88);
        check(32'(cin), 32'(TYPE_CODE_VALUE));
        check(rd, 32'h0000_1234);
    endtask
    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_process();
        t_types();
        t_areas();
        t_coupler();
        t_command();
        t_stall();
        stop_test();
    end
endmodule // terminal_channel_register_set_tb_top

// file: rtl/terminal_channel_pkg.sv
// Constants, types and reset values for the terminal channel register set.
// Assumes one 100 MHz clock, a synchronous active-low reset and an Avalon-MM host.
// How it works
// R1: each of two logical channels owns its own 64-word register set
// R2: words 0-7 are working-storage process variables beside the cyclic image
// R3: words 8-15 return fixed type constants; writes leave them unchanged
// R4: words 16-31 manufacturer, 32-47 user, 48-63 extended area decoded separately; here manufacturer and user words share one RAM range
// R5: words 0-5 hold terminal-specific values, here plain storage
// R6: word 6 is diagnostics; it flags refused writes from the coupler
// R7: word 7 takes parameter/number on write, returns result/number on read
// R8: word 8 returns the terminal type code
// R9: word 9 returns the firmware version as ASCII major and minor
// R10: word 10 returns shift register count and length in bits
// R11: word 11 returns the number of logical channels
// R12: word 12 gives minimum transfer length per byte; MSB drops status byte
// R13: data type codes 0x00, 0x01, 0x03, 0x05 mean none, byte, word, dword arrays
// R14: codes 0x11-0x16 repeat 0x01-0x06 with variable channel length
// R15: the coupler places the control/status byte beside the data bytes
// R16: without status byte the terminal presents two user data bytes per channel
// R17: control bit 7 set makes user data carry register contents
// R18: control bit 6 clear reads a register, set writes the user data
// R19: control bits 0-5 give the register index, reaching all 64 words
// R20: an access is complete once the status byte equals the control byte
// R21: unimplemented extended words read zero and ignore writes
// R22: the coupler holds the control byte until completion is seen
package terminal_channel_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int CHANNELS    = 2;
    localparam int REG_WORDS   = 64;
    localparam int RAM_WORDS   = 40;

    // register indices
    localparam logic [5:0] PROC_VAR_LAST          = 6'h07;
    localparam logic [5:0] DIAGNOSTIC_INFO        = 6'h06;
    localparam logic [5:0] FUNCTION_COMMAND       = 6'h07;
    localparam logic [5:0] TERMINAL_TYPE_CODE     = 6'h08;
    localparam logic [5:0] FIRMWARE_VERSION       = 6'h09;
    localparam logic [5:0] SHIFT_REGISTER_LENGTH  = 6'h0A;
    localparam logic [5:0] LOGICAL_CHANNEL_COUNT  = 6'h0B;
    localparam logic [5:0] MINIMUM_TRANSFER_LEN   = 6'h0C;
    localparam logic [5:0] CHANNEL_DATA_TYPE      = 6'h0D;
    localparam logic [5:0] TYPE_AREA_LAST         = 6'h0F;
    localparam logic [5:0] MANUFACTURER_FIRST     = 6'h10;
    localparam logic [5:0] USER_AREA_FIRST        = 6'h20;
    localparam logic [5:0] USER_AREA_LAST         = 6'h2F;
    localparam logic [5:0] EXTENDED_FIRST         = 6'h30;

    // data type codes
    localparam logic [7:0] DATA_TYPE_NONE         = 8'h00;
    localparam logic [7:0] DATA_TYPE_BYTE_ARRAY   = 8'h01;
    localparam logic [7:0] DATA_TYPE_WORD_ARRAY   = 8'h03;
    localparam logic [7:0] DATA_TYPE_DWORD_ARRAY  = 8'h05;
    localparam logic [7:0] DATA_TYPE_VARIABLE     = 8'h10;
    // this terminal keeps a fixed logical channel length
    localparam logic       CHANNEL_LENGTH_VARIABLE = 1'b0;

    // type register contents; the type code and version are arbitrary values
    localparam logic [15:0] TYPE_CODE_VALUE       = 16'h0001;
    localparam logic [15:0] FIRMWARE_VALUE        = 16'h3130;
    localparam logic [15:0] SHIFT_LENGTH_VALUE    = 16'h0110;
    localparam logic [15:0] CHANNEL_COUNT_VALUE   = 16'h0002;
    localparam logic [15:0] MIN_TRANSFER_VALUE    = 16'h0202;
    localparam logic [15:0] DATA_TYPE_VALUE       = {8'h00, DATA_TYPE_WORD_ARRAY};

    // control byte fields and the diagnostic refused bit
    localparam int CTRL_REG_MODE_BIT  = 7;
    localparam int CTRL_WRITE_BIT     = 6;
    localparam int DIAG_REFUSED_BIT   = 0;

    // bus byte addresses
    localparam int          BUS_ADDR_W        = 10;
    localparam int          LOCAL_SPACE_BIT   = 9;
    localparam int          CHANNEL_BIT       = 8;
    localparam logic [9:0]  LINK_CONTROL_ADDR = 10'h200;
    localparam logic [9:0]  LINK_STATUS_ADDR  = 10'h204;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_e;

    typedef struct packed {
        logic [CHANNELS-1:0][RAM_WORDS-1:0][15:0] ram;
        logic [CHANNELS-1:0][7:0]                 result;
        logic [CHANNELS-1:0][7:0]                 status;
        logic [CHANNELS-1:0][15:0]                in_data;
        logic [CHANNELS-1:0]                      status_en;
        bus_state_e                               bus_state;
        logic                                     waitreq;
        logic [31:0]                              rdata;
    } state_s;

    localparam state_s STATE_RESET = '{
        ram:       '0,
        result:    '0,
        status:    '0,
        in_data:   '0,
        status_en: '0,
        bus_state: BUS_IDLE,
        waitreq:   1'b1,
        rdata:     32'h0000_0000
    };

endpackage

// file: rtl/terminal_channel_register_set.sv
// Two-channel register set of an analog input terminal, with the coupler-side
// process image and an Avalon-MM slave for the terminal's local processor.
// Assumes coupler inputs are synchronous to ref_clk_i and change only per cycle.
module terminal_channel_register_set
    import terminal_channel_pkg::*;
(
    input  wire logic                              ref_clk_i,
    input  wire logic                              rst_n_i,
    input  wire logic [BUS_ADDR_W-1:0]             avs_address_i,
    input  wire logic                              avs_read_i,
    input  wire logic                              avs_write_i,
    input  wire logic [31:0]                       avs_writedata_i,
    output logic      [31:0]                       avs_readdata_o,
    output logic                                   avs_waitrequest_o,
    input  wire logic [CHANNELS-1:0][7:0]          ctrl_byte_i,
    input  wire logic [CHANNELS-1:0][15:0]         out_data_i,
    output logic      [CHANNELS-1:0][7:0]          status_byte_o,
    output logic      [CHANNELS-1:0][15:0]         in_data_o
);

    ////////////////////////////////////////////////////////////////////////////
    // area decoding

    function automatic logic is_ram(input logic [5:0] idx);
        return (idx <= PROC_VAR_LAST) ||                                           // R2 R5
               ((idx >= MANUFACTURER_FIRST) && (idx <= USER_AREA_LAST));           // R4
    endfunction

    // manufacturer and user words follow the eight process variables in storage
    function automatic logic [5:0] ram_slot(input logic [5:0] idx);
        if (idx <= PROC_VAR_LAST)
        begin
            return idx;
        end
        return 6'(idx - 6'h08);
    endfunction

    function automatic logic [15:0] type_word(input logic [5:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            TERMINAL_TYPE_CODE:    v = TYPE_CODE_VALUE;                            // R8
            FIRMWARE_VERSION:      v = FIRMWARE_VALUE;                             // R9
            SHIFT_REGISTER_LENGTH: v = SHIFT_LENGTH_VALUE;                         // R10
            LOGICAL_CHANNEL_COUNT: v = CHANNEL_COUNT_VALUE;                        // R11
            MINIMUM_TRANSFER_LEN:  v = MIN_TRANSFER_VALUE;                         // R12
            CHANNEL_DATA_TYPE:
            begin
                v      = DATA_TYPE_VALUE;                                          // R13
                // a variable channel length moves the code up by 0x10
                v[7:0] = CHANNEL_LENGTH_VARIABLE ? (v[7:0] | DATA_TYPE_VARIABLE) : v[7:0]; // R14
            end
            default:               v = 16'h0000;
        endcase
        return v;
    endfunction

    // coupler view: the command word reads back result over function number
    function automatic logic [15:0] read_word(input state_s s, input int ch, input logic [5:0] idx,
                                              input logic coupler_view);
        logic [15:0] v;
        v = 16'h0000;
        if (idx == FUNCTION_COMMAND && coupler_view)
        begin
            v = {s.result[ch], s.ram[ch][FUNCTION_COMMAND][7:0]};                  // R7
        end
        else if (is_ram(idx))
        begin
            v = s.ram[ch][ram_slot(idx)];                                          // R1
        end
        else if (idx <= TYPE_AREA_LAST)
        begin
            v = type_word(idx);                                                    // R3
        end
        else
        begin
            v = 16'h0000;                                                          // R21
        end
        return v;
    endfunction

    // status byte off when disabled or when the minimum length MSB drops it
    function automatic logic status_allowed(input logic en, input int ch);
        return en && !MIN_TRANSFER_VALUE[8*ch+7];                                  // R12
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    state_s r;
    state_s next_r;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic                  coupler_busy;
        logic [7:0]            ctl;
        logic [5:0]            idx;
        logic [5:0]            bus_idx;
        logic                  bus_ch;
        logic                  reg_mode;

        next_r       = r;
        coupler_busy = 1'b0;
        ctl          = 8'h00;
        idx          = 6'h00;
        bus_idx      = avs_address_i[7:2];
        bus_ch       = avs_address_i[CHANNEL_BIT];
        reg_mode     = 1'b0;

        // a pending coupler access owns the storage this cycle
        for (int c = 0; c < CHANNELS; c++)
        begin
            ctl = ctrl_byte_i[c];
            if (status_allowed(r.status_en[c], c) && ctl[CTRL_REG_MODE_BIT] && (ctl != r.status[c]))
            begin
                coupler_busy = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // avalon slave: one wait cycle, more while a coupler access is pending, then a single-cycle answer
        case (r.bus_state)
            BUS_IDLE:
            begin
                next_r.waitreq = 1'b1;
                if ((avs_read_i || avs_write_i) && !coupler_busy)
                begin
                    next_r.waitreq   = 1'b0;
                    next_r.bus_state = BUS_ACK;
                    next_r.rdata     = 32'h0000_0000;
                    if (avs_address_i[LOCAL_SPACE_BIT])
                    begin
                        if (avs_address_i == LINK_CONTROL_ADDR)
                        begin
                            if (avs_write_i)
                            begin
                                next_r.status_en = avs_writedata_i[CHANNELS-1:0];
                            end
                            next_r.rdata = {30'h0, r.status_en};
                        end
                        else if (avs_address_i == LINK_STATUS_ADDR)
                        begin
                            next_r.rdata = {16'h0000, r.status[1], r.status[0]};
                        end
                    end
                    else if (avs_address_i[1:0] == 2'b00)
                    begin
                        if (avs_write_i)
                        begin
                            if (bus_idx == FUNCTION_COMMAND)
                            begin
                                // local software answers the command here
                                next_r.result[bus_ch] = avs_writedata_i[15:8];     // R7
                            end
                            else if (is_ram(bus_idx))
                            begin
                                next_r.ram[bus_ch][ram_slot(bus_idx)] = avs_writedata_i[15:0]; // R2
                            end
                        end
                        else
                        begin
                            next_r.rdata = {16'h0000, read_word(r, int'(bus_ch), bus_idx, 1'b0)};
                        end
                    end
                end
            end
            BUS_ACK:
            begin
                // released by the master at this edge; never answer twice
                next_r.waitreq   = 1'b1;
                next_r.bus_state = BUS_IDLE;
            end
            default:
            begin
                next_r.waitreq   = 1'b1;
                next_r.bus_state = BUS_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////////
        // coupler process image, evaluated every cycle per channel
        for (int c = 0; c < CHANNELS; c++)
        begin
            ctl      = ctrl_byte_i[c];
            idx      = ctl[5:0];                                                   // R19
            reg_mode = status_allowed(r.status_en[c], c) && ctl[CTRL_REG_MODE_BIT]; // R17
            if (!status_allowed(r.status_en[c], c))
            begin
                // plain two bytes of user data, no status byte in use
                next_r.status[c]  = 8'h00;                                         // R16
                next_r.in_data[c] = r.ram[c][0];                                   // R16
            end
            else if (!reg_mode)
            begin
                next_r.status[c]  = 8'h00;                                         // R15
                next_r.in_data[c] = r.ram[c][0];
            end
            else if (ctl != r.status[c])
            begin
                // one access per new control byte; a held byte is not repeated
                if (ctl[CTRL_WRITE_BIT])                                           // R18
                begin
                    next_r.in_data[c] = 16'h0000;
                    if ((idx != DIAGNOSTIC_INFO) && is_ram(idx))
                    begin
                        next_r.ram[c][ram_slot(idx)] = out_data_i[c];              // R7
                    end
                    else
                    begin
                        // refused write: type words, diagnostics, extended area
                        next_r.ram[c][DIAGNOSTIC_INFO][DIAG_REFUSED_BIT] = 1'b1;   // R6
                    end
                end
                else
                begin
                    next_r.in_data[c] = read_word(r, c, idx, 1'b1);                // R18
                end
                next_r.status[c] = ctl;                                            // R20
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            r <= STATE_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign avs_readdata_o    = r.rdata;
    assign avs_waitrequest_o = r.waitreq;
    assign status_byte_o     = r.status;
    assign in_data_o         = r.in_data;

endmodule // terminal_channel_register_set
